// ### msd_regs.vh
// constants of the multi-stream transfer controller
`ifndef MSD_REGS_VH
`define MSD_REGS_VH
`define MSD_NUM_STREAMS   8
`define MSD_DIR_M2M       2'h0
`define MSD_DIR_P2M       2'h1
`define MSD_DIR_M2P       2'h2
`define MSD_SIZE_BYTE     2'h0
`define MSD_SIZE_HALF     2'h1
`define MSD_SIZE_WORD     2'h2
`define MSD_CFG_DIR_LSB   0
`define MSD_CFG_CIRC_BIT  2
`define MSD_CFG_DBUF_BIT  3
`define MSD_CFG_SSZ_LSB   4
`define MSD_CFG_DSZ_LSB   6
`define MSD_CFG_BURST_LSB 8
`define MSD_CFG_WIDTH     10
`define MSD_FIFO_DEPTH    4
`endif

// ### msd_fifo.v
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module msd_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             sys_clk,  // system clock
    input  wire             nrst,     // async reset, active low
    input  wire             clr,      // flush contents
    input  wire [WIDTH-1:0] in_data,  // write data
    input  wire             in_valid, // write request
    output wire             in_ready, // not full
    output reg  [WIDTH-1:0] out_data, // registered read data
    output reg              out_valid,// read data present
    input  wire             out_ready // consumer takes data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wptr_reg;
    reg [AW-1:0]    rptr_reg;
    reg [AW:0]      cnt_reg;
    wire            push;
    wire            pop;
    wire            load;

    localparam [AW:0] FULL = DEPTH;

    assign in_ready = (cnt_reg != FULL);
    assign push     = in_valid && in_ready;
    // output register refills when empty or consumed
    assign load     = (cnt_reg != {(AW+1){1'b0}}) && (!out_valid || out_ready);
    assign pop      = load;

    always @(posedge sys_clk) begin
        if (push) begin
            mem[wptr_reg] <= in_data;
        end
    end

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wptr_reg  <= {AW{1'b0}};
            rptr_reg  <= {AW{1'b0}};
            cnt_reg   <= {(AW+1){1'b0}};
            out_valid <= 1'b0;
            out_data  <= {WIDTH{1'b0}};
        end else if (clr) begin
            wptr_reg  <= {AW{1'b0}};
            rptr_reg  <= {AW{1'b0}};
            cnt_reg   <= {(AW+1){1'b0}};
            out_valid <= 1'b0;
        end else begin
            if (push) begin
                wptr_reg <= wptr_reg + 1'b1;
            end
            if (pop) begin
                rptr_reg <= rptr_reg + 1'b1;
                out_data <= mem[rptr_reg];
            end
            if (push && !pop) begin
                cnt_reg <= cnt_reg + 1'b1;
            end else if (pop && !push) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
            if (pop) begin
                out_valid <= 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ### msd_dma.v
// eight-stream transfer controller core with two master ports
`timescale 1ns/1ps
`default_nettype none
`include "msd_regs.vh"
// Function
// - eight streams, each with its own configuration and transfer state
// - read on port A, write on port B, two separate master ports
// - per stream direction: memory-memory, peripheral-memory, memory-peripheral
// - all data, memory or peripheral, passes through one shared fifo
// - burst transfers of several beats per grant
// - circular mode reloads address and count at buffer end
// - double-buffer mode alternates two destination addresses on completion
// - each stream has its own hardware request line from a peripheral
// - each stream may be started by a software trigger
// - source and destination item sizes independent, one item written per item read
// - request lines serve serial, audio, two-wire, timer, sd, converter peripherals
module msd_dma #(
    parameter NS = 8,
    parameter AW = 32,
    parameter CW = 16
) (
    input  wire             sys_clk,   // system clock, 40 MHz
    input  wire             nrst,      // async reset, active low
    input  wire [NS-1:0]    cfg_en,    // stream enable
    input  wire [NS*`MSD_CFG_WIDTH-1:0] cfg_mode, // per-stream mode fields
    input  wire [NS*AW-1:0] cfg_src,   // per-stream source address
    input  wire [NS*AW-1:0] cfg_dst,   // per-stream destination address
    input  wire [NS*AW-1:0] cfg_dst1,  // per-stream second memory buffer
    input  wire [NS*CW-1:0] cfg_cnt,   // per-stream item count
    input  wire [NS-1:0]    sw_trig,   // software start, one-cycle pulse
    input  wire [NS-1:0]    hw_req,    // peripheral request lines, async
    input  wire [NS-1:0]    clr_done,  // clear complete flag
    input  wire [NS-1:0]    clr_err,   // clear error flag
    output reg  [NS-1:0]    done_flag, // transfer complete, sticky
    output reg  [NS-1:0]    err_flag,  // bus fault, sticky
    output reg  [NS-1:0]    cur_buf,   // active memory buffer per stream
    output reg  [AW-1:0]    rd_addr,   // port A address
    output reg  [1:0]       rd_size,   // port A item size
    output wire             rd_req,    // port A read request
    input  wire             rd_ack,    // port A data valid
    input  wire [31:0]      rd_data,   // port A read data
    input  wire             rd_err,    // port A bus fault
    output reg  [AW-1:0]    wr_addr,   // port B address
    output reg  [1:0]       wr_size,   // port B item size
    output wire             wr_req,    // port B write request
    output wire [31:0]      wr_data,   // port B write data
    input  wire             wr_ack,    // port B write taken
    input  wire             wr_err     // port B bus fault
);
    // ----------------------------------------
    // states
    // ----------------------------------------
    localparam ST_IDLE = 2'h0;
    localparam ST_RUN  = 2'h1;
    localparam ST_END  = 2'h2;

    reg  [NS-1:0]  req_s1_reg;
    reg  [NS-1:0]  req_s2_reg;
    reg  [NS-1:0]  pend_reg;
    reg  [AW-1:0]  sa_reg [0:NS-1];
    reg  [AW-1:0]  da_reg [0:NS-1];
    reg  [CW-1:0]  left_reg [0:NS-1];
    reg  [1:0]     state_reg;
    reg  [2:0]     gnt_reg;
    reg  [1:0]     beats_reg;
    reg  [2:0]     issued_reg;
    reg  [2:0]     sel;
    reg            any;
    reg            rd_busy_reg;
    integer        k;
    integer        j;

    wire [`MSD_CFG_WIDTH-1:0] m = cfg_mode[gnt_reg*`MSD_CFG_WIDTH +: `MSD_CFG_WIDTH];
    wire [1:0] dir   = m[`MSD_CFG_DIR_LSB +: 2];
    wire       circ  = m[`MSD_CFG_CIRC_BIT];
    wire       dbuf  = m[`MSD_CFG_DBUF_BIT];
    wire [1:0] ssz   = m[`MSD_CFG_SSZ_LSB +: 2];
    wire [1:0] dsz   = m[`MSD_CFG_DSZ_LSB +: 2];
    wire [1:0] burst = m[`MSD_CFG_BURST_LSB +: 2];
    wire [2:0] sstep_b = (ssz == `MSD_SIZE_WORD) ? 3'h4 :
                         (ssz == `MSD_SIZE_HALF) ? 3'h2 : 3'h1;
    wire [2:0] dstep_b = (dsz == `MSD_SIZE_WORD) ? 3'h4 :
                         (dsz == `MSD_SIZE_HALF) ? 3'h2 : 3'h1;
    wire [AW-1:0] sstep = {{(AW-3){1'b0}}, sstep_b};
    wire [AW-1:0] dstep = {{(AW-3){1'b0}}, dstep_b};

    // ----------------------------------------
    // request capture
    // ----------------------------------------
    // requests come from other logic blocks of unknown timing, so synchronise
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            req_s1_reg <= {NS{1'b0}};
            req_s2_reg <= {NS{1'b0}};
        end else begin
            req_s1_reg <= hw_req;
            req_s2_reg <= req_s1_reg;
        end
    end

    // fixed priority, lowest stream wins
    always @* begin
        sel = 3'h0;
        any = 1'b0;
        for (j = NS-1; j >= 0; j = j - 1) begin
            if (pend_reg[j] && cfg_en[j]) begin
                sel = j[2:0];
                any = 1'b1;
            end
        end
    end

    // ----------------------------------------
    // datapath through fifo
    // ----------------------------------------
    wire        f_in_ready;
    wire        f_out_valid;
    wire [31:0] f_out_data;
    // destination narrower than source keeps low lanes; wider is zero-extended
    wire [31:0] packed_rd = (ssz == `MSD_SIZE_BYTE) ? {24'h000000, rd_data[7:0]} :
                            (ssz == `MSD_SIZE_HALF) ? {16'h0000, rd_data[15:0]} : rd_data;
    wire        aborting  = rd_err || wr_err;

    // reads stop at the burst length and at the items still owed, so the fifo
    // is empty whenever the grant passes to another stream
    wire [2:0] inflight = issued_reg - {1'b0, beats_reg};
    wire       rd_room  = (issued_reg <= {1'b0, burst}) &&
                          ({{(CW-3){1'b0}}, inflight} < left_reg[gnt_reg]);

    assign rd_req  = (state_reg == ST_RUN) && !rd_busy_reg && f_in_ready && rd_room;
    assign wr_req  = f_out_valid;
    assign wr_data = (dsz == `MSD_SIZE_BYTE) ? {24'h000000, f_out_data[7:0]} :
                     (dsz == `MSD_SIZE_HALF) ? {16'h0000, f_out_data[15:0]} :
                     f_out_data;

    msd_fifo #(
        .WIDTH(32),
        .DEPTH(`MSD_FIFO_DEPTH),
        .AW(2)
    ) u_fifo (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .clr      (aborting),
        .in_data  (packed_rd),
        .in_valid (rd_ack),
        .in_ready (f_in_ready),
        .out_data (f_out_data),
        .out_valid(f_out_valid),
        .out_ready(wr_ack)
    );

    // ----------------------------------------
    // stream engine
    // ----------------------------------------
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg   <= ST_IDLE;
            gnt_reg     <= 3'h0;
            beats_reg   <= 2'h0;
            issued_reg  <= 3'h0;
            rd_busy_reg <= 1'b0;
            pend_reg    <= {NS{1'b0}};
            done_flag   <= {NS{1'b0}};
            err_flag    <= {NS{1'b0}};
            cur_buf     <= {NS{1'b0}};
            rd_addr     <= {AW{1'b0}};
            wr_addr     <= {AW{1'b0}};
            rd_size     <= 2'h0;
            wr_size     <= 2'h0;
            for (k = 0; k < NS; k = k + 1) begin
                sa_reg[k]   <= {AW{1'b0}};
                da_reg[k]   <= {AW{1'b0}};
                left_reg[k] <= {CW{1'b0}};
            end
        end else begin
            pend_reg  <= (pend_reg | sw_trig | req_s2_reg) & cfg_en;
            done_flag <= done_flag & ~clr_done;
            err_flag  <= err_flag & ~clr_err;
            for (k = 0; k < NS; k = k + 1) begin
                // reload every cycle while disabled; addresses also while an enabled idle stream has no items left
                if (!cfg_en[k] || (left_reg[k] == {CW{1'b0}} && !(state_reg != ST_IDLE
                        && gnt_reg == k[2:0]))) begin
                    sa_reg[k]   <= cfg_src[k*AW +: AW];
                    da_reg[k]   <= cur_buf[k] ? cfg_dst1[k*AW +: AW] : cfg_dst[k*AW +: AW];
                    left_reg[k] <= cfg_en[k] ? left_reg[k] : cfg_cnt[k*CW +: CW];
                end
            end
            case (state_reg)
                ST_IDLE: begin
                    if (any && left_reg[sel] != {CW{1'b0}}) begin
                        // addresses stand before the first request is raised
                        gnt_reg    <= sel;
                        beats_reg  <= 2'h0;
                        issued_reg <= 3'h0;
                        rd_addr    <= sa_reg[sel];
                        wr_addr    <= da_reg[sel];
                        rd_size    <= cfg_mode[sel*`MSD_CFG_WIDTH + `MSD_CFG_SSZ_LSB +: 2];
                        wr_size    <= cfg_mode[sel*`MSD_CFG_WIDTH + `MSD_CFG_DSZ_LSB +: 2];
                        state_reg  <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (rd_req) begin
                        rd_busy_reg <= 1'b1;
                        issued_reg  <= issued_reg + 3'h1;
                    end
                    if (rd_ack) begin
                        rd_busy_reg <= 1'b0;
                        // peripheral side holds its address fixed
                        if (dir != `MSD_DIR_P2M) begin
                            sa_reg[gnt_reg] <= sa_reg[gnt_reg] + sstep;
                            rd_addr         <= sa_reg[gnt_reg] + sstep;
                        end
                    end
                    if (wr_ack) begin
                        if (dir != `MSD_DIR_M2P) begin
                            da_reg[gnt_reg] <= da_reg[gnt_reg] + dstep;
                            wr_addr         <= da_reg[gnt_reg] + dstep;
                        end
                        left_reg[gnt_reg] <= left_reg[gnt_reg] - 1'b1;
                        beats_reg <= beats_reg + 1'b1;
                        if (left_reg[gnt_reg] == {{(CW-1){1'b0}}, 1'b1}) begin
                            state_reg <= ST_END;
                        end else if (beats_reg == burst) begin
                            // burst over: give other streams a chance
                            state_reg <= ST_IDLE;
                            pend_reg[gnt_reg] <= (dir == `MSD_DIR_M2M) | req_s2_reg[gnt_reg];
                        end
                    end
                    if (aborting) begin
                        err_flag[gnt_reg]  <= 1'b1;
                        pend_reg[gnt_reg]  <= 1'b0;
                        left_reg[gnt_reg]  <= {CW{1'b0}};
                        rd_busy_reg        <= 1'b0;
                        state_reg          <= ST_IDLE;
                    end
                end
                ST_END: begin
                    done_flag[gnt_reg] <= 1'b1;
                    if (dbuf) begin
                        cur_buf[gnt_reg] <= ~cur_buf[gnt_reg];
                        da_reg[gnt_reg]  <= cur_buf[gnt_reg] ? cfg_dst[gnt_reg*AW +: AW]
                                                             : cfg_dst1[gnt_reg*AW +: AW];
                    end else if (circ) begin
                        da_reg[gnt_reg] <= cfg_dst[gnt_reg*AW +: AW];
                    end
                    if (dbuf || circ) begin
                        sa_reg[gnt_reg]   <= cfg_src[gnt_reg*AW +: AW];
                        left_reg[gnt_reg] <= cfg_cnt[gnt_reg*CW +: CW];
                    end else begin
                        pend_reg[gnt_reg] <= 1'b0;
                    end
                    state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ### msd_dma_sva.sv
// port-level assertions for the transfer controller core
`timescale 1ns/1ps
`default_nettype none
module msd_dma_sva #(
    parameter NS = 8,
    parameter AW = 32,
    parameter CW = 16
) (
    input wire logic          sys_clk,   // system clock
    input wire logic          nrst,      // async reset, active low
    input wire logic [NS-1:0] clr_done,  // complete clear
    input wire logic [NS-1:0] clr_err,   // error clear
    input wire logic [NS-1:0] done_flag, // complete flags
    input wire logic [NS-1:0] err_flag,  // error flags
    input wire logic [1:0]    rd_size,   // read item size
    input wire logic          rd_req,    // read request
    input wire logic          rd_ack,    // read answer
    input wire logic          rd_err,    // read fault
    input wire logic [AW-1:0] wr_addr,   // write address
    input wire logic          wr_req,    // write request
    input wire logic [31:0]   wr_data,   // write data
    input wire logic          wr_ack     // write taken
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    property p_rd_pulse; rd_req |=> !rd_req; endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("read request too long");
    property p_ack_to_wr; rd_ack && !rd_err |-> ##2 wr_req; endproperty
    a_ack_to_wr: assert property (p_ack_to_wr) else $error("read word lost");
    property p_wr_hold; wr_req && !wr_ack && !rd_err |=> wr_req && $stable(wr_data)
        && $stable(wr_addr); endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write dropped early");
    property p_done_keep; 1 |=> (($past(done_flag) & ~$past(clr_done)) & ~done_flag) == 0;
    endproperty
    a_done_keep: assert property (p_done_keep) else $error("complete flag lost");
    property p_err_set; rd_err |-> ##[1:2] (err_flag != 0); endproperty
    a_err_set: assert property (p_err_set) else $error("fault not flagged");
    property p_size; rd_req |-> rd_size != 2'h3; endproperty
    a_size: assert property (p_size) else $error("bad read size");
    property p_done_cause; ((done_flag & ~$past(done_flag)) != 0) |->
        ($past(wr_ack) || $past(wr_ack, 2)); endproperty
    a_done_cause: assert property (p_done_cause) else $error("complete without write");
    property p_err_keep; 1 |=> (($past(err_flag) & ~$past(clr_err)) & ~err_flag) == 0;
    endproperty
    a_err_keep: assert property (p_err_keep) else $error("error flag lost");
endmodule
bind msd_dma msd_dma_sva #(.NS(NS), .AW(AW), .CW(CW)) i_msd_dma_sva (.sys_clk(sys_clk),
    .nrst(nrst), .clr_done(clr_done), .clr_err(clr_err), .done_flag(done_flag), .err_flag(err_flag),
    .rd_size(rd_size), .rd_req(rd_req), .rd_ack(rd_ack), .rd_err(rd_err), .wr_addr(wr_addr),
    .wr_req(wr_req), .wr_data(wr_data), .wr_ack(wr_ack));
`default_nettype wire

// ### msd_bus_model.sv
// memory and peripheral slaves behind both master ports
`timescale 1ns/1ps
`default_nettype none
module msd_bus_model #(
    parameter logic [31:0] KEY = 32'h0
) (
    input wire logic        sys_clk,   // system clock
    input wire logic        nrst,      // reset, active low
    input wire logic [3:0]  lat,       // answer delay
    input wire logic        fault,     // answer reads with a fault
    input wire logic        wfault,    // answer writes with a fault
    input wire logic        rd_req,    // read request
    input wire logic [31:0] rd_addr,   // read address
    output logic            rd_ack,    // read answer
    output logic [31:0]     rd_data,   // read data
    output logic            rd_err,    // read fault
    input wire logic        wr_req,    // write request
    input wire logic [31:0] wr_addr,   // write address
    input wire logic [31:0] wr_data,   // write data
    output logic            wr_ack,    // write taken
    output logic            wr_err,    // write fault
    output logic [31:0]     last_addr, // last written address
    output logic [31:0]     last_data  // last written data
);
    logic        rbusy;
    logic [3:0]  rcnt;
    logic [3:0]  wcnt;
    logic [31:0] raddr;
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            {rd_ack, rd_err, wr_ack, wr_err, rbusy, rcnt, wcnt} <= '0;
            {rd_data, raddr, last_addr, last_data} <= '0;
        end else begin
            rd_ack <= 1'b0;
            rd_err <= 1'b0;
            wr_ack <= 1'b0;
            wr_err <= 1'b0;
            // data is only meaningful with the answer
            rd_data <= ~rd_data;
            if (rd_req) begin
                rbusy <= 1'b1;
                raddr <= rd_addr;
                rcnt <= lat;
            end else if (rbusy && rcnt == 4'h0) begin
                rbusy <= 1'b0;
                rd_ack <= 1'b1;
                rd_err <= fault;
                rd_data <= raddr ^ KEY;
            end else if (rbusy) begin
                rcnt <= rcnt - 4'h1;
            end
            if (wr_req && !wr_ack) begin
                wcnt <= (wcnt >= lat) ? 4'h0 : wcnt + 4'h1;
                if (wcnt >= lat) begin
                    wr_ack <= 1'b1;
                    wr_err <= wfault;
                    last_addr <= wr_addr;
                    last_data <= wr_data;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### msd_dma_tb_top.sv
// self-checking bench for the transfer controller core
`timescale 1ns/1ps
`default_nettype none
`include "msd_regs.vh"
module msd_dma_tb_top;
    localparam logic [31:0] KEY = 32'hc3a50f1e;
    logic         sys_clk = 1'b0;
    logic         nrst = 1'b0;
    logic [7:0]   cfg_en = '0, sw_trig = '0, hw_req = '0, clr_done = '0, clr_err = '0;
    logic [79:0]  cfg_mode = '0;
    logic [255:0] cfg_src = '0, cfg_dst = '0, cfg_dst1 = '0;
    logic [127:0] cfg_cnt = '0;
    logic [3:0]   lat = 4'h1;
    logic         fault = 1'b0, wfault = 1'b0;
    logic [7:0]   done_flag, err_flag, cur_buf;
    logic [31:0]  rd_addr, rd_data, wr_addr, wr_data, last_addr, last_data;
    logic [1:0]   rd_size, wr_size;
    logic         rd_req, rd_ack, rd_err, wr_req, wr_ack, wr_err;
    int           errors = 0;
    int           checks = 0;
    always #12.5 sys_clk = ~sys_clk;
    msd_dma i_msd_dma (.sys_clk(sys_clk), .nrst(nrst), .cfg_en(cfg_en), .cfg_mode(cfg_mode),
        .cfg_src(cfg_src), .cfg_dst(cfg_dst), .cfg_dst1(cfg_dst1), .cfg_cnt(cfg_cnt),
        .sw_trig(sw_trig), .hw_req(hw_req), .clr_done(clr_done), .clr_err(clr_err),
        .done_flag(done_flag), .err_flag(err_flag), .cur_buf(cur_buf), .rd_addr(rd_addr),
        .rd_size(rd_size), .rd_req(rd_req), .rd_ack(rd_ack), .rd_data(rd_data), .rd_err(rd_err),
        .wr_addr(wr_addr), .wr_size(wr_size), .wr_req(wr_req), .wr_data(wr_data),
        .wr_ack(wr_ack), .wr_err(wr_err));
    msd_bus_model #(.KEY(KEY)) i_msd_bus_model (.sys_clk(sys_clk), .nrst(nrst), .lat(lat),
        .fault(fault), .wfault(wfault), .rd_req(rd_req), .rd_addr(rd_addr), .rd_ack(rd_ack),
        .rd_data(rd_data), .rd_err(rd_err), .wr_req(wr_req), .wr_addr(wr_addr),
        .wr_data(wr_data), .wr_ack(wr_ack), .wr_err(wr_err), .last_addr(last_addr),
        .last_data(last_data));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic summarize;
        if (errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED time=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cfg(input int s, input logic [9:0] m, input logic [31:0] src, dst, dst1,
                       input logic [15:0] cnt);
        cfg_mode[s*10 +: 10] = m;
        cfg_src[s*32 +: 32] = src;
        cfg_dst[s*32 +: 32] = dst;
        cfg_dst1[s*32 +: 32] = dst1;
        cfg_cnt[s*16 +: 16] = cnt;
        // the count is taken while the stream is still off
        @(posedge sys_clk);
        #1;
        cfg_en[s] = 1'b1;
    endtask
    // w: 0 start, 1 clear complete, 2 clear error
    task automatic pulse(input int w, input logic [7:0] m);
        @(posedge sys_clk);
        #1;
        if (w == 0) sw_trig = m;
        if (w == 1) clr_done = m;
        if (w == 2) clr_err = m;
        @(posedge sys_clk);
        #1;
        {sw_trig, clr_done, clr_err} = '0;
    endtask
    // bounded wait on a complete (e=0) or error (e=1) flag
    task automatic wait_flag(input int s, input bit e);
        int n;
        n = 0;
        while ((e ? err_flag[s] : done_flag[s]) !== 1'b1 && n < 2000) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if ((e ? err_flag[s] : done_flag[s]) !== 1'b1) begin
            errors++;
            summarize();
        end
    endtask
    function automatic logic [9:0] md(input logic [1:0] d, input logic c, b2, input logic [1:0] ss,
                                      ds, bl);
        return {bl, ds, ss, b2, c, d};
    endfunction
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_burst_m2m;
        cfg(0, md(`MSD_DIR_M2M, 0, 0, `MSD_SIZE_WORD, `MSD_SIZE_WORD, 2'h1), 32'h100, 32'h200,
            32'h0, 16'h3);
        pulse(0, 8'h01);
        wait_flag(0, 0);
        chk(last_addr, 32'h208);
        chk(last_data, 32'h108 ^ KEY);
        pulse(1, 8'h01);
        chk(done_flag, 8'h00);
        cfg_en[0] = 1'b0;
    endtask
    task automatic t_priority;
        cfg(2, md(`MSD_DIR_M2M, 0, 0, `MSD_SIZE_WORD, `MSD_SIZE_WORD, 2'h0), 32'h300, 32'h400,
            32'h0, 16'h1);
        cfg(5, md(`MSD_DIR_M2P, 0, 0, `MSD_SIZE_WORD, `MSD_SIZE_WORD, 2'h0), 32'h500, 32'h600,
            32'h0, 16'h1);
        pulse(0, 8'h24);
        wait_flag(2, 0);
        wait_flag(5, 0);
        chk(last_addr, 32'h600);
        chk(done_flag, 8'h24);
        pulse(1, 8'h24);
        chk(done_flag, 8'h00);
        cfg_en = '0;
    endtask
    task automatic t_circ_hw;
        lat = 4'h3;
        cfg(7, md(`MSD_DIR_P2M, 1, 0, `MSD_SIZE_WORD, `MSD_SIZE_WORD, 2'h0), 32'h4000_0000,
            32'h700, 32'h0, 16'h2);
        hw_req[7] = 1'b1;
        wait_flag(7, 0);
        pulse(1, 8'h80);
        wait_flag(7, 0);
        chk(last_data, 32'h4000_0000 ^ KEY);
        chk(last_addr, 32'h704);
        hw_req[7] = 1'b0;
        cfg_en[7] = 1'b0;
        repeat (40) @(posedge sys_clk);
        #1;
        pulse(1, 8'h80);
        lat = 4'h1;
    endtask
    task automatic t_dbuf;
        cfg(1, md(`MSD_DIR_M2M, 0, 1, `MSD_SIZE_WORD, `MSD_SIZE_WORD, 2'h0), 32'h800, 32'ha00,
            32'hb00, 16'h1);
        pulse(0, 8'h02);
        wait_flag(1, 0);
        chk(last_addr, 32'ha00);
        chk({31'h0, cur_buf[1]}, 32'h1);
        pulse(1, 8'h02);
        pulse(0, 8'h02);
        wait_flag(1, 0);
        chk(last_addr, 32'hb00);
        chk({31'h0, cur_buf[1]}, 32'h0);
        cfg_en[1] = 1'b0;
    endtask
    task automatic t_pack;
        cfg(4, md(`MSD_DIR_M2M, 0, 0, `MSD_SIZE_BYTE, `MSD_SIZE_WORD, 2'h0), 32'h801, 32'h900,
            32'h0, 16'h2);
        pulse(0, 8'h10);
        wait_flag(4, 0);
        chk(last_addr, 32'h904);
        chk(last_data, (32'h802 ^ KEY) & 32'hff);
        chk({28'h0, wr_size, rd_size}, 32'h8);
        cfg_en[4] = 1'b0;
    endtask
    // first pass faults the read port, second pass the write port
    task automatic t_fault;
        for (int p = 0; p < 2; p++) begin
            fault = (p == 0);
            wfault = (p == 1);
            cfg(3, md(`MSD_DIR_M2M, 0, 0, `MSD_SIZE_WORD, `MSD_SIZE_WORD, 2'h0), 32'hc00,
                32'hd00, 32'h0, 16'h2);
            pulse(0, 8'h08);
            wait_flag(3, 1);
            {fault, wfault} = 2'h0;
            chk(err_flag, 8'h08);
            pulse(2, 8'h08);
            chk(err_flag, 8'h00);
            cfg_en[3] = 1'b0;
        end
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        #1;
        nrst = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        t_burst_m2m();
        t_priority();
        t_circ_hw();
        t_dbuf();
        t_pack();
        t_fault();
        summarize();
    end
endmodule
`default_nettype wire
